/* File: inc/rbq_pkg.sv */
// constants and types for the reset and bus quiesce block
// How it works
// - while reset is held, all three strobes read high and the data bus floats.
// - after reset falls, address and program counter clear once two full cycles complete (RBQ_HOLD and the first RBQ_CLEARED cycle).
// - after reset rises, execution restarts from address zero one full cycle later.
// - reset edges arrive at any phase and are synchronised, so latency varies.
// - never more than one of the three strobes is active at once.
// - a write interrupted by reset may show an invalid address.
package rbq_pkg;
  localparam int unsigned ADDR_W        = 16;
  localparam int unsigned DATA_W        = 16;
  localparam int unsigned MIN_RESET_CYC = 5;
  localparam logic [ADDR_W-1:0] RESET_ADDR = 16'h0000;

  typedef enum logic [1:0] {
    RBQ_RUN     = 2'b00,
    RBQ_HOLD    = 2'b01,
    RBQ_CLEARED = 2'b10,
    RBQ_RESTART = 2'b11
  } rbq_state_t;

  typedef enum logic [1:0] {
    RBQ_CYC_NONE = 2'b00,
    RBQ_CYC_MEM  = 2'b01,
    RBQ_CYC_IO   = 2'b10,
    RBQ_CYC_WR   = 2'b11
  } rbq_cycle_t;
endpackage

/* File: core/rbq_reset_bus_quiesce.sv */
// reset response and bus quiesce of the external bus interface
`timescale 1ns/1ps
module rbq_reset_bus_quiesce #(
  parameter int unsigned ADDR_W = rbq_pkg::ADDR_W,
  parameter int unsigned DATA_W = rbq_pkg::DATA_W
) (
  input  wire logic                    ref_clk,
  input  wire logic                    rst_n,
  input  wire logic                    reset_in_n,
  input  wire rbq_pkg::rbq_cycle_t     core_cycle,
  input  wire logic [ADDR_W-1:0]       core_addr,
  input  wire logic [DATA_W-1:0]       core_wdata,
  output logic [ADDR_W-1:0]            address_outputs,
  output logic                         io_data_strobe_n,
  output logic                         write_strobe_n,
  output logic                         memory_strobe_n,
  output logic [DATA_W-1:0]            data_bus_out,
  output logic                         data_bus_oe,
  output logic                         core_run,
  output logic [ADDR_W-1:0]            program_counter
);
  import rbq_pkg::*;

  logic [2:0]        sync;
  logic [2:0]        next_sync;
  logic              rst_seen;
  logic              next_rst_seen;
  rbq_state_t        state;
  rbq_state_t        next_state;
  logic [ADDR_W-1:0] next_address;
  logic [ADDR_W-1:0] next_pc;
  logic              next_io;
  logic              next_wr;
  logic              next_mem;
  logic [DATA_W-1:0] next_dout;
  logic              next_oe;
  logic              next_run;

  // three-stage synchroniser; level accepted only when stages two and three agree
  always_comb begin
    next_sync     = {sync[1:0], reset_in_n};
    next_rst_seen = rst_seen;
    if (sync[2] == sync[1]) begin
      next_rst_seen = ~sync[2];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sync     <= 3'h7;
      rst_seen <= 1'b0;
    end else begin
      sync     <= next_sync;
      rst_seen <= next_rst_seen;
    end
  end

  // no reset length is counted; a low that stages two and three agree on is taken, the source must hold five cycles
  always_comb begin
    next_state       = state;
    next_address     = address_outputs;
    next_pc          = program_counter;
    next_io          = 1'b1;
    next_wr          = 1'b1;
    next_mem         = 1'b1;
    next_dout        = data_bus_out;
    next_oe          = 1'b0;
    next_run         = 1'b0;
    case (state)
      RBQ_RUN: begin
        if (rst_seen) begin
          next_state = RBQ_HOLD;
        end else begin
          next_run     = 1'b1;
          next_address = core_addr;
          next_pc      = core_addr;
          // one-hot decode keeps at most one strobe low
          case (core_cycle)
            RBQ_CYC_MEM: next_mem = 1'b0;
            RBQ_CYC_IO: next_io = 1'b0;
            RBQ_CYC_WR: begin
              next_wr   = 1'b0;
              next_oe   = 1'b1;
              next_dout = core_wdata;
            end
            default: next_mem = 1'b1;
          endcase
        end
      end
      RBQ_HOLD: begin
        // address left as it stood through this cycle and the first RBQ_CLEARED cycle; an aborted write shows it
        next_state = RBQ_CLEARED;
      end
      RBQ_CLEARED: begin
        next_address = RESET_ADDR;
        next_pc      = RESET_ADDR;
        if (!rst_seen) begin
          next_state = RBQ_RESTART;
        end
      end
      RBQ_RESTART: begin
        next_address = RESET_ADDR;
        next_pc      = RESET_ADDR;
        if (rst_seen) begin
          next_state = RBQ_CLEARED;
        end else begin
          next_state = RBQ_RUN;
          next_run   = 1'b1;
        end
      end
      default: next_state = RBQ_HOLD;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state            <= RBQ_CLEARED;
      address_outputs  <= RESET_ADDR;
      program_counter  <= RESET_ADDR;
      io_data_strobe_n <= 1'b1;
      write_strobe_n   <= 1'b1;
      memory_strobe_n  <= 1'b1;
      data_bus_out     <= '0;
      data_bus_oe      <= 1'b0;
      core_run         <= 1'b0;
    end else begin
      state            <= next_state;
      address_outputs  <= next_address;
      program_counter  <= next_pc;
      io_data_strobe_n <= next_io;
      write_strobe_n   <= next_wr;
      memory_strobe_n  <= next_mem;
      data_bus_out     <= next_dout;
      data_bus_oe      <= next_oe;
      core_run         <= next_run;
    end
  end
endmodule

/* File: tb/rbq_reset_src.sv */
// reset pin source model
`timescale 1ns/1ps
module rbq_reset_src (
  input  wire logic ref_clk,
  output logic      reset_in_n = 1'b1
);
  // edges land at a random point inside the cycle
  task automatic set_level(input logic v);
    @(posedge ref_clk);
    #(1 + $urandom_range(3));
    reset_in_n = v;
  endtask
endmodule

/* File: tb/rbq_reset_bus_quiesce_assertions.sv */
// port checker
`timescale 1ns/1ps
module rbq_reset_bus_quiesce_assertions (
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        reset_in_n,
  input wire logic [15:0] address_outputs,
  input wire logic        io_data_strobe_n,
  input wire logic        write_strobe_n,
  input wire logic        memory_strobe_n,
  input wire logic        data_bus_oe,
  input wire logic        core_run
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  property p_quiet; !reset_in_n [*6] |-> io_data_strobe_n & write_strobe_n & memory_strobe_n & !data_bus_oe; endproperty
  a_quiet: assert property (p_quiet) else $error("bus active");
  property p_clear; !reset_in_n [*8] |-> address_outputs == 16'h0000 && !core_run; endproperty
  a_clear: assert property (p_clear) else $error("not cleared");
  property p_excl; $onehot0({!io_data_strobe_n, !write_strobe_n, !memory_strobe_n}); endproperty
  a_excl: assert property (p_excl) else $error("two strobes");
  property p_go; $rose(reset_in_n) |-> ##[2:8] core_run && address_outputs == 16'h0000; endproperty
  a_go: assert property (p_go) else $error("no restart");
  // while the core is halted the bus must be released, whatever the reset phase
  property p_idle; !core_run |-> io_data_strobe_n & write_strobe_n & memory_strobe_n & !data_bus_oe; endproperty
  a_idle: assert property (p_idle) else $error("bus active while halted");
  property p_zero; !core_run [*3] |-> address_outputs == 16'h0000; endproperty
  a_zero: assert property (p_zero) else $error("address not cleared");
endmodule
bind rbq_reset_bus_quiesce rbq_reset_bus_quiesce_assertions rbq_reset_bus_quiesce_assertions_i (
  .ref_clk          (ref_clk),
  .rst_n            (rst_n),
  .reset_in_n       (reset_in_n),
  .address_outputs  (address_outputs),
  .io_data_strobe_n (io_data_strobe_n),
  .write_strobe_n   (write_strobe_n),
  .memory_strobe_n  (memory_strobe_n),
  .data_bus_oe      (data_bus_oe),
  .core_run         (core_run)
);

/* File: tb/reset_bus_quiesce_tb.sv */
// bench
`timescale 1ns/1ps
module rbq_reset_bus_quiesce_tb;
  import rbq_pkg::*;
  logic ref_clk = 0, rst_n = 0, reset_in_n, io_data_strobe_n, write_strobe_n, memory_strobe_n, data_bus_oe, core_run;
  logic [15:0] core_addr = 0, core_wdata = 0, address_outputs, data_bus_out, program_counter;
  rbq_cycle_t core_cycle = RBQ_CYC_NONE;
  wire [2:0] act = ~{memory_strobe_n, io_data_strobe_n, write_strobe_n};
  wire wr_req = core_cycle == RBQ_CYC_WR;
  wire [15:0] seen_wdata = data_bus_oe ? data_bus_out : 16'h0000;
  logic [51:0] q[$];
  int err_count = 0, compares = 0, n = 0;
  always #2.5 ref_clk = ~ref_clk;
  rbq_reset_src rbq_reset_src_i (
    .ref_clk    (ref_clk),
    .reset_in_n (reset_in_n)
  );
  rbq_reset_bus_quiesce rbq_reset_bus_quiesce_i (
    .ref_clk          (ref_clk),
    .rst_n            (rst_n),
    .reset_in_n       (reset_in_n),
    .core_cycle       (core_cycle),
    .core_addr        (core_addr),
    .core_wdata       (core_wdata),
    .address_outputs  (address_outputs),
    .io_data_strobe_n (io_data_strobe_n),
    .write_strobe_n   (write_strobe_n),
    .memory_strobe_n  (memory_strobe_n),
    .data_bus_out     (data_bus_out),
    .data_bus_oe      (data_bus_oe),
    .core_run         (core_run),
    .program_counter  (program_counter)
  );
  task automatic check(input logic [63:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: %h", $time, seen);
    end
  endtask
  task automatic test_done;
    $display("err_count %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    if (++n > 999) begin
      err_count++;
      test_done();
    end
    #1;
    if (act !== 3'b000) begin
      check({act, data_bus_oe, address_outputs, program_counter, seen_wdata}, q.pop_front());
    end
  end
  initial begin
    void'($urandom(32'h7137));
    repeat (6) @(negedge ref_clk);
    rst_n = 1;
    repeat (4) begin
      repeat (40) begin
        @(negedge ref_clk);
        core_cycle = rbq_cycle_t'(2'($urandom));
        core_addr = 16'($urandom);
        core_wdata = 16'($urandom);
        if (core_run && core_cycle) q.push_back({3'b100 >> (core_cycle - 1), wr_req, core_addr, core_addr,
                                                 wr_req ? core_wdata : 16'h0000});
      end
      @(negedge ref_clk);
      core_cycle = RBQ_CYC_NONE;
      rbq_reset_src_i.set_level(0);
      repeat (9) @(negedge ref_clk);
      check({act, data_bus_oe, core_run, address_outputs, program_counter}, 0);
      rbq_reset_src_i.set_level(1);
      repeat (9) @(negedge ref_clk);
      check({q.size() == 0, core_run}, 2'b11);
    end
    test_done();
  end
endmodule
